// ### mrb_regs.sv
// Mode register bank: drive strength, temperature status, identity
//
// Functional notes
// R01: Index 03h holds a write-only 4-bit drive code, 0001b/0010b/0011b, default 0010b.
// R02: Codes 1001b, 1010b, 1011b give asymmetric strengths; other codes are reserved.
// R03: Index 04h reports a read-only 3-bit refresh-rate field, 000b/111b = limits exceeded.
// R04: Rate codes 001b, 010b, 011b ask for 4x, 2x and 1x refresh intervals.
// R05: Rate codes 100b, 101b, 110b ask for half, quarter, quarter with derating.
// R06: On derating the controller adds 1.875 ns to core row timings.
// R07: Bit 2 of the rate field is one whenever the die is above 85 C.
// R08: Bit 7 of index 04h is set when the rate field changed since the last read.
// R09: A read of index 04h clears the update flag.
// R10: The update flag is zero after power-up.
// R11: The controller treats rate codes 000b and 111b as an alarm.
// R12: Index 05h returns a read-only 8-bit maker code.
// R13: Index 06h returns a read-only 8-bit silicon revision code.
// R14: Index 07h returns a second read-only 8-bit revision code.
// R15: Index 08h bits 1:0 hold the memory type code.
// R16: Index 08h bits 5:2 hold density and bits 7:6 the I/O width.
// R17: Reserved bits read as zero and writes to read-only registers are ignored.
`timescale 1ns/100ps
module mrb_regs #(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] REV_CODE = 8'h3c, // Arbitrary value
    parameter logic [7:0] REV2_CODE = 8'ha5, // Arbitrary value
    parameter logic [1:0] TYPE_CODE = 2'h2, // Arbitrary value
    parameter logic [3:0] DENSITY_CODE = 4'he, // 6Gb die
    parameter logic [1:0] WIDTH_CODE = 2'h0 // x32
) (
    input wire logic clk_sys, // System clock, 100 MHz
    input wire logic rst_n, // Async reset, active low
    input mrb_pkg::mrb_cmd_t cmd, // Mode register command
    output mrb_pkg::mrb_rsp_t rsp, // Read answer, one cycle later
    input wire logic [2:0] sensor_rate, // Rate code from sensor, async
    output mrb_pkg::mrb_drive_t drive, // Active output impedance
    output logic [3:0] drive_code, // Stored drive code
    output logic temp_hot, // Above 85 C
    output logic derate_req, // Core timing derating needed
    output logic temp_alarm // Operating limit exceeded
);

    // ****************************************
    // Sensor input crossing
    // ****************************************
    logic [2:0] rate_sync;

    // Sensor runs on its own timing, so synchronise first
    mrb_sync #(
        .W(3),
        .RST_VAL(mrb_pkg::RR_RESET)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d(sensor_rate),
        .q(rate_sync)
    );

    // ****************************************
    // Command decode
    // ****************************************
    logic wr_drive;
    logic rd_temp;
    logic code_ok;

    // Strobes for the registers with side effects
    always_comb begin
        wr_drive = cmd.wr && (cmd.index == mrb_pkg::IDX_IO_DRIVE);
        rd_temp = cmd.rd && (cmd.index == mrb_pkg::IDX_TEMP);
        code_ok = mrb_pkg::drv_legal(cmd.data[mrb_pkg::DRV_MSB:0]);
    end

    // ****************************************
    // Drive strength register
    // ****************************************
    logic [3:0] code_q;
    logic [3:0] code_d;
    mrb_pkg::mrb_drive_t drv_dec;
    mrb_pkg::mrb_drive_t drv_q;
    mrb_pkg::mrb_drive_t drv_d;

    // Reserved codes are dropped so the pad never sees them
    always_comb begin
        code_d = code_q;
        if (wr_drive && code_ok) begin
            code_d = cmd.data[mrb_pkg::DRV_MSB:0]; // R01 R02
        end
        drv_d = drv_dec;
    end

    // Decode ahead of the flop so the impedance leaves from a register
    mrb_drive_dec u_dec (
        .code(code_d),
        .drive(drv_dec)
    );

    // Code and decoded impedance stay in step
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            code_q <= mrb_pkg::DRV_RESET; // R01
            drv_q <= '{mrb_pkg::MRB_IMP_40, mrb_pkg::MRB_IMP_40};
        end else begin
            code_q <= code_d;
            drv_q <= drv_d;
        end
    end

    assign drive = drv_q;
    assign drive_code = code_q;

    // ****************************************
    // Temperature status register
    // ****************************************
    logic [2:0] rate_q;
    logic [2:0] rate_d;
    logic flag_q;
    logic flag_d;
    logic rate_chg;
    logic [2:0] ind_d;
    logic [2:0] ind_q;

    // A change in the same cycle as a read wins over the clear
    always_comb begin
        rate_d = rate_sync;
        rate_chg = (rate_sync != rate_q);
        flag_d = flag_q;
        if (rate_chg) begin
            flag_d = 1'b1; // R08
        end else if (rd_temp) begin
            flag_d = 1'b0; // R09
        end
        ind_d[0] = rate_d[mrb_pkg::HOT_BIT]; // R07
        ind_d[1] = (rate_d == mrb_pkg::RR_QTR_DERATE); // R05
        ind_d[2] = (rate_d == mrb_pkg::RR_LOW_LIMIT) ||
                   (rate_d == mrb_pkg::RR_HIGH_LIMIT); // R11
    end

    // Rate resets to nominal so no change is seen at power-up
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rate_q <= mrb_pkg::RR_RESET;
            flag_q <= 1'b0; // R10
            ind_q <= 3'h0;
        end else begin
            rate_q <= rate_d; // R03 R04 R05
            flag_q <= flag_d;
            ind_q <= ind_d;
        end
    end

    assign temp_hot = ind_q[0];
    assign derate_req = ind_q[1];
    assign temp_alarm = ind_q[2];

    // ****************************************
    // Read answer
    // ****************************************
    mrb_pkg::mrb_rsp_t rsp_q;
    mrb_pkg::mrb_rsp_t rsp_d;

    // Write-only and unmapped indices read as zero
    always_comb begin
        rsp_d.valid = cmd.rd;
        rsp_d.data = mrb_pkg::ZERO_BYTE; // R17
        if (cmd.rd) begin
            case (cmd.index)
                mrb_pkg::IDX_TEMP: begin
                    rsp_d.data[mrb_pkg::RATE_MSB:0] = rate_q; // R03
                    rsp_d.data[mrb_pkg::FLAG_BIT] = flag_q; // R08
                end
                mrb_pkg::IDX_MAKER: begin
                    rsp_d.data = MAKER_CODE; // R12
                end
                mrb_pkg::IDX_REV1: begin
                    rsp_d.data = REV_CODE; // R13
                end
                mrb_pkg::IDX_REV2: begin
                    rsp_d.data = REV2_CODE; // R14
                end
                mrb_pkg::IDX_GEOM: begin
                    rsp_d.data = {WIDTH_CODE, DENSITY_CODE, TYPE_CODE}; // R15 R16
                end
                default: begin
                    rsp_d.data = mrb_pkg::ZERO_BYTE;
                end
            endcase
        end
    end

    // Answer registered so data leaves from flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    assign rsp = rsp_q;

    // ****************************************
    // Assertions
    // ****************************************
    logic init_q;
    logic init_d;

    // Marks the first cycle after reset release
    always_comb begin
        init_d = 1'b0;
    end

    // Only the reset branch sets it, so it is high for one edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            init_q <= 1'b1;
        end else begin
            init_q <= init_d;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_temp_read;
        cmd.rd && (cmd.index == mrb_pkg::IDX_TEMP);
    endsequence

    sequence s_id_read(logic [7:0] idx);
        cmd.rd && (cmd.index == idx);
    endsequence

    sequence s_code_write(logic legal);
        wr_drive && (code_ok == legal);
    endsequence

    // ****************************************
    // Update flag checks
    // ****************************************

    a_flag_after_reset: assert property (init_q |-> !flag_q) // R10
        else $error("update flag not zero after reset");

    a_flag_on_change: assert property ($changed(rate_sync) |-> ##1 flag_q) // R08
        else $error("rate change did not raise update flag");

    // Cleared flag may only come back through a fresh change
    a_flag_cleared: assert property ( // R09
        s_temp_read ##0 !rate_chg |=> !flag_q ##1 (flag_q == $past(rate_chg)))
        else $error("read did not clear update flag");

    // Set beats clear, so a change during the read is not lost
    a_flag_set_wins: assert property (s_temp_read ##0 rate_chg |=> flag_q) // R08
        else $error("change in read cycle lost update flag");

    a_flag_sticky: assert property (flag_q && !rd_temp |=> flag_q) // R08
        else $error("update flag lost without a read");

    // ****************************************
    // Refresh-rate and indicator checks
    // ****************************************

    // Rate field lags the synchronised code by one edge
    a_rate_tracks: assert property (rate_q == $past(rate_sync)) // R03
        else $error("rate field does not follow sensor");

    a_hot_reported: assert property (temp_hot == rate_q[mrb_pkg::HOT_BIT]) // R07
        else $error("hot indicator wrong");

    a_derate_flag: assert property ( // R05
        derate_req == (rate_q == mrb_pkg::RR_QTR_DERATE))
        else $error("derating request wrong");

    a_alarm_match: assert property ( // R03
        temp_alarm == (rate_q == mrb_pkg::RR_LOW_LIMIT || rate_q == mrb_pkg::RR_HIGH_LIMIT))
        else $error("limit alarm wrong");

    // ****************************************
    // Drive strength checks
    // ****************************************

    // Written code takes effect on the next edge
    a_code_legal_write: assert property ( // R01
        s_code_write(1'b1) |=> code_q == $past(cmd.data[mrb_pkg::DRV_MSB:0]))
        else $error("legal drive code not stored");

    a_code_reserved_keep: assert property (s_code_write(1'b0) |=> $stable(code_q)) // R02
        else $error("reserved drive code changed register");

    a_code_after_reset: assert property (init_q |-> code_q == mrb_pkg::DRV_RESET) // R01
        else $error("drive code default wrong");

    a_drive_default: assert property ( // R01
        init_q |-> drive.pull_down == mrb_pkg::MRB_IMP_40 && drive.pull_up == mrb_pkg::MRB_IMP_40)
        else $error("default impedance wrong");

    // A reserved code in the register would decode to the MRB_IMP_40 fallback on both halves
    a_code_never_reserved: assert property (mrb_pkg::drv_legal(code_q)) // R02
        else $error("reserved drive code stored");

    a_asym_decode: assert property ( // R02
        code_q == mrb_pkg::DRV_34PD_48PU |->
        drive.pull_down == mrb_pkg::MRB_IMP_34 && drive.pull_up == mrb_pkg::MRB_IMP_48)
        else $error("asymmetric drive decode wrong");

    // ****************************************
    // Read answer checks
    // ****************************************

    // Answer shows the values of the read cycle, before the clear
    a_temp_read_data: assert property ( // R03 R17
        s_temp_read |=> rsp.valid && rsp.data[2:0] == $past(rate_q) &&
        rsp.data[7] == $past(flag_q) && rsp.data[6:3] == 4'h0)
        else $error("temperature read data wrong");

    a_maker_read: assert property ( // R12
        s_id_read(mrb_pkg::IDX_MAKER) |=> rsp.data == MAKER_CODE)
        else $error("maker code wrong");

    a_rev_read: assert property ( // R13
        s_id_read(mrb_pkg::IDX_REV1) |=> rsp.data == REV_CODE)
        else $error("revision code wrong");

    a_rev2_read: assert property ( // R14
        s_id_read(mrb_pkg::IDX_REV2) |=> rsp.data == REV2_CODE)
        else $error("second revision code wrong");

    a_geom_read: assert property ( // R15 R16
        s_id_read(mrb_pkg::IDX_GEOM) |=>
        rsp.data == {WIDTH_CODE, DENSITY_CODE, TYPE_CODE})
        else $error("geometry code wrong");

    a_wo_reads_zero: assert property ( // R17
        s_id_read(mrb_pkg::IDX_IO_DRIVE) |=> rsp.valid && rsp.data == 8'h00)
        else $error("write-only register read not zero");

    a_idle_data_zero: assert property (!rsp.valid |-> rsp.data == 8'h00) // R17
        else $error("answer data not zero while idle");

    // Exactly one answer per read, none otherwise
    a_no_idle_answer: assert property (!cmd.rd |=> !rsp.valid) // R17
        else $error("answer without read");

endmodule

// ### mrb_pkg.sv
// Package: mode register bank constants, codes and carriers
package mrb_pkg;

    // ****************************************
    // Mode register indices
    // ****************************************
    localparam logic [7:0] IDX_IO_DRIVE = 8'h03;
    localparam logic [7:0] IDX_TEMP = 8'h04;
    localparam logic [7:0] IDX_MAKER = 8'h05;
    localparam logic [7:0] IDX_REV1 = 8'h06;
    localparam logic [7:0] IDX_REV2 = 8'h07;
    localparam logic [7:0] IDX_GEOM = 8'h08;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int DRV_MSB = 3;
    localparam int RATE_MSB = 2;
    localparam int HOT_BIT = 2;
    localparam int FLAG_BIT = 7;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Drive strength codes
    localparam logic [3:0] DRV_34 = 4'h1;
    localparam logic [3:0] DRV_40 = 4'h2;
    localparam logic [3:0] DRV_48 = 4'h3;
    localparam logic [3:0] DRV_34PD_40PU = 4'h9;
    localparam logic [3:0] DRV_40PD_48PU = 4'ha;
    localparam logic [3:0] DRV_34PD_48PU = 4'hb;
    localparam logic [3:0] DRV_RESET = DRV_40;

    // Refresh-rate codes
    localparam logic [2:0] RR_LOW_LIMIT = 3'h0;
    localparam logic [2:0] RR_X4 = 3'h1;
    localparam logic [2:0] RR_X2 = 3'h2;
    localparam logic [2:0] RR_X1 = 3'h3;
    localparam logic [2:0] RR_HALF = 3'h4;
    localparam logic [2:0] RR_QTR = 3'h5;
    localparam logic [2:0] RR_QTR_DERATE = 3'h6;
    localparam logic [2:0] RR_HIGH_LIMIT = 3'h7;
    localparam logic [2:0] RR_RESET = RR_X1;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        MRB_IMP_OFF = 2'h0,
        MRB_IMP_34 = 2'h1,
        MRB_IMP_40 = 2'h2,
        MRB_IMP_48 = 2'h3
    } mrb_imp_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] index;
        logic [7:0] data;
    } mrb_cmd_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } mrb_rsp_t;

    typedef struct packed {
        mrb_imp_t pull_down;
        mrb_imp_t pull_up;
    } mrb_drive_t;

    // Legal drive strength code check
    function automatic logic drv_legal(input logic [3:0] code);
        drv_legal = (code == DRV_34) || (code == DRV_40) || (code == DRV_48) ||
                    (code == DRV_34PD_40PU) || (code == DRV_40PD_48PU) ||
                    (code == DRV_34PD_48PU);
    endfunction

endpackage

// ### mrb_sync.sv
// Two-flop synchroniser for the sensor refresh-rate code
`timescale 1ns/100ps
module mrb_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [W-1:0] d, // Asynchronous input
    output logic [W-1:0] q // Synchronised output
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] q_d;

    // First stage feeds only the second
    always_comb begin
        meta_d = d;
        q_d = meta_q;
    end

    // Both stages reset to a constant
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_q <= meta_d;
            q <= q_d;
        end
    end
endmodule

// ### mrb_drive_dec.sv
// Decoder from drive strength code to pull-up and pull-down impedance
`timescale 1ns/100ps
module mrb_drive_dec (
    input wire logic [3:0] code, // Drive strength code
    output mrb_pkg::mrb_drive_t drive // Decoded impedance pair
);
    // Symmetric codes drive both halves alike
    always_comb begin
        case (code)
            mrb_pkg::DRV_34: begin
                drive = '{mrb_pkg::MRB_IMP_34, mrb_pkg::MRB_IMP_34};
            end
            mrb_pkg::DRV_40: begin
                drive = '{mrb_pkg::MRB_IMP_40, mrb_pkg::MRB_IMP_40};
            end
            mrb_pkg::DRV_48: begin
                drive = '{mrb_pkg::MRB_IMP_48, mrb_pkg::MRB_IMP_48};
            end
            mrb_pkg::DRV_34PD_40PU: begin
                drive = '{mrb_pkg::MRB_IMP_34, mrb_pkg::MRB_IMP_40};
            end
            mrb_pkg::DRV_40PD_48PU: begin
                drive = '{mrb_pkg::MRB_IMP_40, mrb_pkg::MRB_IMP_48};
            end
            mrb_pkg::DRV_34PD_48PU: begin
                drive = '{mrb_pkg::MRB_IMP_34, mrb_pkg::MRB_IMP_48};
            end
            default: begin
                // Never reached from a stored code; fall back to default
                drive = '{mrb_pkg::MRB_IMP_40, mrb_pkg::MRB_IMP_40};
            end
        endcase
    end
endmodule

// ### mrb_ctrl_model.sv
// Memory controller model issuing mode register commands
`timescale 1ns/100ps
module mrb_ctrl_model #(
    parameter real ROW_DELAY_NS = 18.0 // Plain base activate-to-access delay
) (
    input wire logic clk_sys, // System clock
    output mrb_pkg::mrb_cmd_t cmd, // Mode register command
    input wire logic derate_req, // Derating request from device
    input wire logic temp_alarm // Operating limit exceeded
);
    real act_to_access_delay; // Delay the controller currently uses
    logic alarm_seen; // Latched limit alarm

    initial begin
        cmd = '0;
        act_to_access_delay = ROW_DELAY_NS;
        alarm_seen = 1'b0;
    end

    // One command per call; back-to-back calls keep the strobe up
    task automatic issue(input logic wr, input logic rd, input logic [7:0] idx,
                         input logic [7:0] data);
        @(posedge clk_sys);
        cmd <= '{wr: wr, rd: rd, index: idx, data: data};
    endtask

    // Idle bus shows inverted stale fields, so nothing leans on old values
    task automatic idle();
        @(posedge clk_sys);
        cmd <= '{wr: 1'b0, rd: 1'b0, index: ~cmd.index, data: ~cmd.data};
    endtask

    // Follow the device's derating and limit indications
    always @(posedge clk_sys) begin
        act_to_access_delay <= derate_req ? ROW_DELAY_NS + 1.875 : ROW_DELAY_NS;
        if (temp_alarm) begin
            alarm_seen <= 1'b1;
        end
    end
endmodule

// ### tb.sv
// Self-checking testbench for the mode register bank
`timescale 1ns/100ps
`define mrb_chk(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
    $display("Error %0t: got %h expected %h", $time, got, exp); end end
module tb;
    // Identity values, arbitrary
    localparam logic [7:0] MAKER = 8'h6b;
    localparam logic [7:0] REV1 = 8'h4d;
    localparam logic [7:0] REV2 = 8'h2e;
    localparam logic [7:0] GEOM = {2'h1, 4'h7, 2'h1};
    localparam logic [7:0] ID_TAB [4] = '{MAKER, REV1, REV2, GEOM};
    logic clk_sys;
    logic rst_n;
    logic [2:0] sensor_rate;
    mrb_pkg::mrb_cmd_t cmd;
    mrb_pkg::mrb_rsp_t rsp;
    mrb_pkg::mrb_drive_t drive;
    mrb_pkg::mrb_drive_t dexp;
    logic [3:0] drive_code;
    logic temp_hot;
    logic derate_req;
    logic temp_alarm;
    logic [7:0] exp_fifo [$];
    logic [7:0] exp_v;
    logic [3:0] code_model;
    logic [2:0] rate_model;
    logic [2:0] r;
    int failures;
    int tests_run;
    int seed;

    mrb_regs #(.MAKER_CODE(MAKER), .REV_CODE(REV1), .REV2_CODE(REV2), .TYPE_CODE(2'h1),
        .DENSITY_CODE(4'h7), .WIDTH_CODE(2'h1)) i_mrb_regs (.clk_sys(clk_sys), .rst_n(rst_n),
        .cmd(cmd), .rsp(rsp), .sensor_rate(sensor_rate), .drive(drive),
        .drive_code(drive_code), .temp_hot(temp_hot), .derate_req(derate_req),
        .temp_alarm(temp_alarm));
    mrb_ctrl_model i_mrb_ctrl_model (.clk_sys(clk_sys), .cmd(cmd), .derate_req(derate_req),
        .temp_alarm(temp_alarm));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic mrb_pkg::mrb_drive_t dec(input logic [3:0] c);
        case (c)
            4'h1: dec = '{mrb_pkg::MRB_IMP_34, mrb_pkg::MRB_IMP_34};
            4'h2: dec = '{mrb_pkg::MRB_IMP_40, mrb_pkg::MRB_IMP_40};
            4'h3: dec = '{mrb_pkg::MRB_IMP_48, mrb_pkg::MRB_IMP_48};
            4'h9: dec = '{mrb_pkg::MRB_IMP_34, mrb_pkg::MRB_IMP_40};
            4'ha: dec = '{mrb_pkg::MRB_IMP_40, mrb_pkg::MRB_IMP_48};
            4'hb: dec = '{mrb_pkg::MRB_IMP_34, mrb_pkg::MRB_IMP_48};
            default: dec = '{mrb_pkg::MRB_IMP_OFF, mrb_pkg::MRB_IMP_OFF};
        endcase
    endfunction

    // Reads note their expected byte before the command goes out
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        exp_fifo.push_back(exp);
        i_mrb_ctrl_model.issue(1'b0, 1'b1, idx, 8'h00);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] data);
        i_mrb_ctrl_model.issue(1'b1, 1'b0, idx, data);
    endtask

    // Release the bus, let n edges pass, then sample mid-cycle
    task automatic settle(input int n);
        i_mrb_ctrl_model.idle();
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic set_rate(input logic [2:0] v);
        @(posedge clk_sys);
        sensor_rate <= v;
        settle(6);
    endtask

    task automatic final_report();
        $display("Checks run %0d, failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Each read answer takes the oldest note off the queue, sampled mid-cycle
    always @(negedge clk_sys) begin
        if (rsp.valid === 1'b1) begin
            exp_v = (exp_fifo.size() > 0) ? exp_fifo.pop_front() : ~rsp.data;
            `mrb_chk(rsp.data, exp_v)
        end
    end

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        failures++;
        $display("Error %0t: timeout", $time);
        final_report();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 32'h798c9325;
        failures = 0;
        tests_run = 0;
        rst_n = 1'b0;
        sensor_rate = 3'h3;
        code_model = 4'h2;
        rate_model = 3'h3;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        settle(1);
        `mrb_chk(drive_code, 4'h2)
        `mrb_chk(drive, dec(4'h2))
        rd(8'h04, 8'h03);
        rd(8'h03, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(8'h04 + 8'(i), 8'($random(seed)));
        end
        rd(8'h04, 8'h03);
        for (int i = 0; i < 4; i++) begin
            rd(8'h05 + 8'(i), ID_TAB[i]);
        end
        // Unmapped places swallow writes and read zero
        for (int i = 0; i < 4; i++) begin
            r = 3'(i);
            wr(8'h09 + 8'($random(seed) & 32'h7f), 8'($random(seed)));
            rd(8'h09 + 8'($random(seed) & 32'h7f), 8'h00);
        end
        settle(2);
        // Every drive code; reserved ones keep the old setting
        for (int c = 0; c < 16; c++) begin
            wr(8'h03, {4'h0, 4'(c)});
            dexp = dec(4'(c));
            if (dexp.pull_down != mrb_pkg::MRB_IMP_OFF) begin
                code_model = 4'(c);
            end
            settle(1);
            `mrb_chk(drive_code, code_model)
            `mrb_chk(drive, dec(code_model))
        end
        // Every refresh-rate code, flag set on change and cleared by read
        for (int c = 0; c < 8; c++) begin
            set_rate(3'(c));
            `mrb_chk(temp_hot, c >= 4)
            `mrb_chk(derate_req, c == 6)
            `mrb_chk(i_mrb_ctrl_model.act_to_access_delay == 19.875, c == 6)
            `mrb_chk(temp_alarm, c == 0 || c == 7)
            rd(8'h04, {3'(c) != rate_model, 4'h0, 3'(c)});
            rd(8'h04, {5'h00, 3'(c)});
            rate_model = 3'(c);
            settle(2);
        end
        `mrb_chk(i_mrb_ctrl_model.alarm_seen, 1'b1)
        // Change and return before a read still leaves the flag set
        r = 3'($random(seed));
        set_rate((r == 3'h7) ? 3'h2 : r);
        set_rate(3'h7);
        rd(8'h04, 8'h87);
        rd(8'h04, 8'h07);
        settle(2);
        // Change landing in the read cycle keeps the flag for the next read
        @(posedge clk_sys);
        sensor_rate <= 3'h1;
        @(posedge clk_sys);
        rd(8'h04, 8'h07);
        rd(8'h04, 8'h81);
        rd(8'h04, 8'h01);
        settle(2);
        // Mid-run reset restores defaults and clears a pending flag
        set_rate(3'h5);
        wr(8'h03, 8'h09);
        settle(1);
        `mrb_chk(drive_code, 4'h9)
        @(posedge clk_sys);
        sensor_rate <= 3'h3;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        settle(1);
        `mrb_chk(drive_code, 4'h2)
        rd(8'h04, 8'h03);
        settle(3);
        `mrb_chk(exp_fifo.size() == 0, 1'b1)
        final_report();
    end
endmodule
